// ===== design/mcis_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mcis_alu (
	// Operation and operands
	input wire mcis_pkg::mcis_op_t op,
	input wire logic [7:0] operand,
	input wire logic [7:0] mem_val,
	input wire logic [7:0] acc_val,
	input wire logic carry_in,
	input wire logic half_carry_in,
	// Result
	output var mcis_pkg::mcis_alu_res_t res
);
	logic lo_fix;
	logic hi_fix;
	logic [7:0] corr;
	logic [8:0] bcd_sum;
	logic [7:0] plus_one;
	logic [7:0] minus_one;

	assign lo_fix = (acc_val[3:0] > mcis_pkg::NIB_MAX) || half_carry_in;
	assign hi_fix = (acc_val[7:4] > mcis_pkg::NIB_MAX) || carry_in;
	assign corr = (lo_fix ? mcis_pkg::LO_CORR : mcis_pkg::BYTE_ZERO)
		| (hi_fix ? mcis_pkg::HI_CORR : mcis_pkg::BYTE_ZERO);
	assign bcd_sum = {1'b0, acc_val} + {1'b0, corr};
	// Byte arithmetic wraps modulo 256
	assign plus_one = mem_val + mcis_pkg::BYTE_ONE;
	assign minus_one = mem_val - mcis_pkg::BYTE_ONE;

	always_comb begin
		res = '0;
		case (op)
			mcis_pkg::op_invert_into_accumulator: begin
				res.acc_we = 1'b1;
				res.acc = ~mem_val;
				res.zero_we = 1'b1;
				res.zero = (~mem_val == mcis_pkg::BYTE_ZERO);
			end
			mcis_pkg::op_bcd_adjust_after_add: begin
				res.mem_we = 1'b1;
				res.mem = bcd_sum[7:0];
				// Decimal overflow past 99 chains into the next byte
				res.carry_we = 1'b1;
				res.carry = hi_fix || bcd_sum[8];
			end
			mcis_pkg::op_subtract_one_in_place: begin
				res.mem_we = 1'b1;
				res.mem = minus_one;
				res.zero_we = 1'b1;
				res.zero = (minus_one == mcis_pkg::BYTE_ZERO);
			end
			mcis_pkg::op_subtract_one_into_accumulator: begin
				res.acc_we = 1'b1;
				res.acc = minus_one;
				res.zero_we = 1'b1;
				res.zero = (minus_one == mcis_pkg::BYTE_ZERO);
			end
			mcis_pkg::op_add_one_in_place: begin
				res.mem_we = 1'b1;
				res.mem = plus_one;
				res.zero_we = 1'b1;
				res.zero = (plus_one == mcis_pkg::BYTE_ZERO);
			end
			mcis_pkg::op_add_one_into_accumulator: begin
				res.acc_we = 1'b1;
				res.acc = plus_one;
				res.zero_we = 1'b1;
				res.zero = (plus_one == mcis_pkg::BYTE_ZERO);
			end
			mcis_pkg::op_power_down: begin
				res.halt = 1'b1;
			end
			mcis_pkg::op_unconditional_branch: begin
				res.branch = 1'b1;
			end
			mcis_pkg::op_data_move_mem_to_acc: begin
				res.acc_we = 1'b1;
				res.acc = mem_val;
			end
			mcis_pkg::op_data_move_imm_to_acc: begin
				res.acc_we = 1'b1;
				res.acc = operand;
			end
			mcis_pkg::op_data_move_acc_to_mem: begin
				res.mem_we = 1'b1;
				res.mem = acc_val;
			end
			default: begin
				res = '0;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== design/mcis_core_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - invert memory byte into accumulator, zero flag
// - low nibble over 9 or half-carry adds 6
// - high nibble over 9 or carry adds 60
// - adjust adds 00/06/60/66, result to memory
// - adjust touches only carry, set past 99
// - subtract one in place, zero flag
// - subtract one into accumulator, memory kept
// - add one in place, zero flag
// - add one into accumulator, memory kept
// - power down stops execution and clock
// - power down keeps memory and registers
// - power down clears watchdog and prescaler
// - power down sets pdown, clears expiry unless a time-out lands that cycle
// - branch loads counter, two cycles, no flags
// - memory to accumulator move, no flags
// - immediate to accumulator move, no flags
// - accumulator to memory move, no flags
module mcis_core_top #(
	parameter int MEM_DEPTH = 64,
	parameter int PRESC_W = 8,
	parameter int WDT_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire mcis_pkg::mcis_axi_req_t s_axi_req,
	output var mcis_pkg::mcis_axi_rsp_t s_axi_rsp,
	// System clock gate
	output var logic sys_clk_off
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam logic [11:0] MEM_END = 12'(mcis_pkg::MEM_BASE + 4 * MEM_DEPTH);
	localparam logic [mcis_pkg::PC_W-1:0] PC_STEP = {{(mcis_pkg::PC_W-1){1'b0}}, 1'b1};

	// Bus state
	logic aw_have_reg, aw_have_next;
	logic [11:0] awaddr_reg, awaddr_next;
	logic w_have_reg, w_have_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	mcis_pkg::mcis_axi_rsp_t rsp_reg, rsp_next;

	// Core state
	mcis_pkg::mcis_state_t state_reg, state_next;
	logic [31:0] instr_reg, instr_next;
	logic [7:0] acc_reg, acc_next;
	logic zero_reg, zero_next;
	logic carry_reg, carry_next;
	logic half_reg, half_next;
	logic pdown_reg, pdown_next;
	logic [mcis_pkg::PC_W-1:0] pc_reg, pc_next;
	logic clk_off_reg, clk_off_next;
	logic [7:0] mem_reg [MEM_DEPTH];
	logic mem_we;
	logic [AW-1:0] mem_wa;
	logic [7:0] mem_wd;

	// Watchdog state
	logic [PRESC_W-1:0] presc_reg, presc_next;
	logic [WDT_W-1:0] wdog_reg, wdog_next;
	logic expiry_reg, expiry_next;

	logic wr_commit;
	logic wr_ok;
	logic [31:0] wr_val;
	logic [AW-1:0] op_addr;
	mcis_pkg::mcis_op_t op;
	mcis_pkg::mcis_alu_res_t alu_res;
	logic halted;

	assign halted = (state_reg == mcis_pkg::st_halted);
	assign op = mcis_pkg::mcis_op_t'(instr_reg[mcis_pkg::OP_LSB +: 4]);
	assign op_addr = instr_reg[mcis_pkg::OPND_LSB +: AW];

	function automatic logic is_mem(input logic [11:0] a);
		is_mem = (a >= mcis_pkg::MEM_BASE) && (a < MEM_END);
	endfunction

	function automatic logic is_hit(input logic [11:0] a);
		is_hit = is_mem(a) || (a == mcis_pkg::INSTR_OFFS) || (a == mcis_pkg::ACC_OFFS)
			|| (a == mcis_pkg::STATUS_OFFS) || (a == mcis_pkg::CTRL_OFFS)
			|| (a == mcis_pkg::PC_OFFS) || (a == mcis_pkg::WDOG_OFFS);
	endfunction

	function automatic logic [31:0] rd_value(input logic [11:0] a);
		logic [31:0] v;
		v = '0;
		if (is_mem(a)) begin
			v = 32'(mem_reg[a[AW+1:2]]);
		end else begin
			case (a)
				mcis_pkg::INSTR_OFFS: v = instr_reg;
				mcis_pkg::ACC_OFFS: v = 32'(acc_reg);
				mcis_pkg::STATUS_OFFS: begin
					v[mcis_pkg::ZERO_BIT] = zero_reg;
					v[mcis_pkg::CARRY_BIT] = carry_reg;
					v[mcis_pkg::HALF_BIT] = half_reg;
					v[mcis_pkg::PDOWN_BIT] = pdown_reg;
					v[mcis_pkg::EXPIRY_BIT] = expiry_reg;
					v[mcis_pkg::BUSY_BIT] = (state_reg == mcis_pkg::st_exec)
						|| (state_reg == mcis_pkg::st_branch_fill);
					v[mcis_pkg::HALTED_BIT] = halted;
				end
				mcis_pkg::PC_OFFS: v = 32'(pc_reg);
				mcis_pkg::WDOG_OFFS: v = 32'(wdog_reg) | (32'(presc_reg) << mcis_pkg::PRESC_FIELD);
				default: v = '0;
			endcase
		end
		rd_value = v;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = m;
	endfunction

	// Writes wait while an instruction is in flight so the two never collide
	assign wr_commit = aw_have_reg && w_have_reg && !rsp_reg.bvalid
		&& ((state_reg == mcis_pkg::st_idle) || halted);
	// Only the wake control is writable while powered down
	assign wr_ok = is_hit(awaddr_reg) && (!halted || (awaddr_reg == mcis_pkg::CTRL_OFFS));
	// A process, not an assign, so register changes seen inside the read mux re-evaluate it
	always_comb begin
		wr_val = merge(rd_value(awaddr_reg), wdata_reg, wstrb_reg);
	end

	mcis_alu u_alu (
		.op(op),
		.operand(instr_reg[mcis_pkg::OPND_LSB +: 8]),
		.mem_val(mem_reg[op_addr]),
		.acc_val(acc_reg),
		.carry_in(carry_reg),
		.half_carry_in(half_reg),
		.res(alu_res)
	);

	always_comb begin
		aw_have_next = aw_have_reg;
		awaddr_next = awaddr_reg;
		w_have_next = w_have_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		rsp_next = rsp_reg;
		if (s_axi_req.awvalid && rsp_reg.awready) begin
			aw_have_next = 1'b1;
			awaddr_next = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && rsp_reg.wready) begin
			w_have_next = 1'b1;
			wdata_next = s_axi_req.wdata;
			wstrb_next = s_axi_req.wstrb;
		end
		if (rsp_reg.bvalid && s_axi_req.bready) begin
			rsp_next.bvalid = 1'b0;
		end
		if (wr_commit) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp = wr_ok ? mcis_pkg::RESP_OKAY : mcis_pkg::RESP_SLVERR;
		end
		rsp_next.awready = !aw_have_next;
		rsp_next.wready = !w_have_next;
		if (rsp_reg.rvalid && s_axi_req.rready) begin
			rsp_next.rvalid = 1'b0;
		end
		if (s_axi_req.arvalid && rsp_reg.arready) begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rdata = rd_value(s_axi_req.araddr);
			rsp_next.rresp = is_hit(s_axi_req.araddr) ? mcis_pkg::RESP_OKAY
				: mcis_pkg::RESP_SLVERR;
		end
		rsp_next.arready = !rsp_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			awaddr_reg <= '0;
			w_have_reg <= 1'b0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			rsp_reg <= '0;
		end else begin
			aw_have_reg <= aw_have_next;
			awaddr_reg <= awaddr_next;
			w_have_reg <= w_have_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			rsp_reg <= rsp_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		instr_next = instr_reg;
		acc_next = acc_reg;
		zero_next = zero_reg;
		carry_next = carry_reg;
		half_next = half_reg;
		pdown_next = pdown_reg;
		pc_next = pc_reg;
		mem_we = 1'b0;
		mem_wa = op_addr;
		mem_wd = alu_res.mem;
		case (state_reg)
			mcis_pkg::st_idle: begin
				if (wr_commit && wr_ok) begin
					if (is_mem(awaddr_reg)) begin
						mem_we = 1'b1;
						mem_wa = awaddr_reg[AW+1:2];
						mem_wd = wr_val[7:0];
					end else begin
						case (awaddr_reg)
							mcis_pkg::INSTR_OFFS: begin
								instr_next = wr_val;
								state_next = mcis_pkg::st_exec;
							end
							mcis_pkg::ACC_OFFS: acc_next = wr_val[7:0];
							mcis_pkg::STATUS_OFFS: begin
								zero_next = wr_val[mcis_pkg::ZERO_BIT];
								carry_next = wr_val[mcis_pkg::CARRY_BIT];
								half_next = wr_val[mcis_pkg::HALF_BIT];
							end
							mcis_pkg::PC_OFFS: pc_next = wr_val[mcis_pkg::PC_W-1:0];
							default: state_next = mcis_pkg::st_idle;
						endcase
					end
				end
			end
			mcis_pkg::st_exec: begin
				// Flags move only where the ALU asks; moves and branch leave them
				if (alu_res.acc_we) begin
					acc_next = alu_res.acc;
				end
				if (alu_res.zero_we) begin
					zero_next = alu_res.zero;
				end
				if (alu_res.carry_we) begin
					carry_next = alu_res.carry;
				end
				mem_we = alu_res.mem_we;
				if (alu_res.branch) begin
					pc_next = instr_reg[mcis_pkg::TGT_LSB +: mcis_pkg::PC_W];
					state_next = mcis_pkg::st_branch_fill;
				end else if (alu_res.halt) begin
					pc_next = pc_reg + PC_STEP;
					pdown_next = 1'b1;
					state_next = mcis_pkg::st_halted;
				end else begin
					pc_next = pc_reg + PC_STEP;
					state_next = mcis_pkg::st_idle;
				end
			end
			mcis_pkg::st_branch_fill: begin
				// Dummy cycle while the new address loads
				state_next = mcis_pkg::st_idle;
			end
			mcis_pkg::st_halted: begin
				// Memory and registers hold; only a wake request resumes
				if (wr_commit && (awaddr_reg == mcis_pkg::CTRL_OFFS)
					&& wr_val[mcis_pkg::WAKE_BIT]) begin
					state_next = mcis_pkg::st_idle;
				end
			end
			default: state_next = mcis_pkg::st_idle;
		endcase
		clk_off_next = (state_next == mcis_pkg::st_halted);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= mcis_pkg::st_idle;
			instr_reg <= '0;
			acc_reg <= '0;
			zero_reg <= 1'b0;
			carry_reg <= 1'b0;
			half_reg <= 1'b0;
			pdown_reg <= 1'b0;
			pc_reg <= '0;
			clk_off_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			instr_reg <= instr_next;
			acc_reg <= acc_next;
			zero_reg <= zero_next;
			carry_reg <= carry_next;
			half_reg <= half_next;
			pdown_reg <= pdown_next;
			pc_reg <= pc_next;
			clk_off_reg <= clk_off_next;
		end
	end

	// Data memory has no reset so its contents survive everything but power loss
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem_reg[mem_wa] <= mem_wd;
		end
	end

	always_comb begin
		presc_next = presc_reg;
		wdog_next = wdog_reg;
		expiry_next = expiry_reg;
		if (state_reg == mcis_pkg::st_exec && alu_res.halt) begin
			presc_next = '0;
			wdog_next = '0;
			expiry_next = 1'b0;
		end else if (!halted) begin
			// Stands still while the clock is off
			presc_next = presc_reg + 1'b1;
			if (&presc_reg) begin
				wdog_next = wdog_reg + 1'b1;
			end
		end
		// A time-out landing on the clearing cycle is not lost
		if (!halted && (&presc_reg) && (&wdog_reg)) begin
			expiry_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_reg <= '0;
			wdog_reg <= '0;
			expiry_reg <= 1'b0;
		end else begin
			presc_reg <= presc_next;
			wdog_reg <= wdog_next;
			expiry_reg <= expiry_next;
		end
	end

	assign s_axi_rsp = rsp_reg;
	assign sys_clk_off = clk_off_reg;
endmodule
`default_nettype wire

// ===== design/mcis_pkg.sv
package mcis_pkg;

	// Register byte addresses
	localparam logic [11:0] INSTR_OFFS = 12'h000;
	localparam logic [11:0] ACC_OFFS = 12'h004;
	localparam logic [11:0] STATUS_OFFS = 12'h008;
	localparam logic [11:0] CTRL_OFFS = 12'h00c;
	localparam logic [11:0] PC_OFFS = 12'h010;
	localparam logic [11:0] WDOG_OFFS = 12'h014;
	localparam logic [11:0] MEM_BASE = 12'h100;

	// Instruction word fields
	localparam int OP_LSB = 0;
	localparam int OPND_LSB = 8;
	localparam int TGT_LSB = 16;
	localparam int PC_W = 11;

	// Status bits
	localparam int ZERO_BIT = 0;
	localparam int CARRY_BIT = 1;
	localparam int HALF_BIT = 2;
	localparam int PDOWN_BIT = 3;
	localparam int EXPIRY_BIT = 4;
	localparam int BUSY_BIT = 5;
	localparam int HALTED_BIT = 6;
	localparam int WAKE_BIT = 0;
	localparam int PRESC_FIELD = 16;

	// Arithmetic constants
	localparam logic [3:0] NIB_MAX = 4'h9;
	localparam logic [7:0] LO_CORR = 8'h06;
	localparam logic [7:0] HI_CORR = 8'h60;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		op_no_operation = 4'h0,
		op_invert_into_accumulator = 4'h1,
		op_bcd_adjust_after_add = 4'h2,
		op_subtract_one_in_place = 4'h3,
		op_subtract_one_into_accumulator = 4'h4,
		op_add_one_in_place = 4'h5,
		op_add_one_into_accumulator = 4'h6,
		op_power_down = 4'h7,
		op_unconditional_branch = 4'h8,
		op_data_move_mem_to_acc = 4'h9,
		op_data_move_imm_to_acc = 4'ha,
		op_data_move_acc_to_mem = 4'hb
	} mcis_op_t;

	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_branch_fill,
		st_halted
	} mcis_state_t;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} mcis_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mcis_axi_rsp_t;

	typedef struct packed {
		logic acc_we;
		logic [7:0] acc;
		logic mem_we;
		logic [7:0] mem;
		logic zero_we;
		logic zero;
		logic carry_we;
		logic carry;
		logic halt;
		logic branch;
	} mcis_alu_res_t;

endpackage

// ===== dv/mcis_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mcis_core_monitor (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus and clock gate
	input wire mcis_pkg::mcis_axi_req_t s_axi_req,
	input wire mcis_pkg::mcis_axi_rsp_t s_axi_rsp,
	input wire logic sys_clk_off
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire logic ar_hit = s_axi_req.arvalid && s_axi_rsp.arready;
	// Power down request taken on a single edge while running
	wire logic go_down = s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid
		&& s_axi_rsp.wready && s_axi_req.awaddr == mcis_pkg::INSTR_OFFS
		&& s_axi_req.wdata[3:0] == 4'h7 && !sys_clk_off;
	chk_b_hold: assert property (s_axi_rsp.bvalid && !s_axi_req.bready |=>
		s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp)) else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rsp.rvalid && !s_axi_req.rready |=>
		s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata)) else $error("read response dropped");
	chk_r_latency: assert property (ar_hit |=> s_axi_rsp.rvalid) else $error("read answer late");
	chk_ar_gap: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
		else $error("second read accepted");
	chk_bad_read: assert property (ar_hit && s_axi_req.araddr >= 12'h200 |=>
		s_axi_rsp.rresp == mcis_pkg::RESP_SLVERR && s_axi_rsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_ctrl_zero: assert property (ar_hit && s_axi_req.araddr == mcis_pkg::CTRL_OFFS |=>
		s_axi_rsp.rdata == 32'h0) else $error("control reads nonzero");
	chk_gate_on: assert property (go_down |-> ##[2:5] sys_clk_off)
		else $error("clock not stopped");
	chk_gate_hold: assert property ($fell(sys_clk_off) |-> $rose(s_axi_rsp.bvalid))
		else $error("clock restarted without wake");
	cover property (ar_hit);
	cover property ($rose(sys_clk_off));
	cover property (s_axi_rsp.bvalid && s_axi_rsp.bresp == mcis_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// ===== dv/mcis_core_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", nm, e, s); end end
module mcis_core_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	mcis_pkg::mcis_axi_req_t req;
	mcis_pkg::mcis_axi_rsp_t rsp;
	logic clk_off;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'hfbd2;
	logic [31:0] d;
	logic [1:0] r;
	int m[8];
	int acc = 0, z = 0, c = 0, h = 0, pc = 0;
	logic [3:0] ops[6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
	int bcd_a[6] = '{'h15, 'h1b, 'h12, 'ha3, 'h35, 'h9a};
	int bcd_f[6] = '{0, 0, 4, 0, 2, 0};
	always #10 aclk = ~aclk;
	mcis_core_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
		.sys_clk_off(clk_off));
	mcis_host_bfm host (.aclk(aclk), .req(req), .rsp(rsp));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [11:0] ma(input int i);
		return mcis_pkg::MEM_BASE + 12'(4 * i);
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wrck(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er,
		input string nm);
		host.wr(a, v, r);
		`CK(nm, er, r)
	endtask
	task automatic rdck(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] e,
		input string nm);
		host.rd(a, d, r);
		`CK(nm, e, d & mk)
	endtask
	// Execute one instruction, advance the model, compare accumulator, addressed byte, three flags and counter
	task automatic run(input logic [3:0] op, input logic [7:0] opnd, input logic [10:0] tgt);
		int a;
		int s;
		a = opnd[5:0];
		wrck(mcis_pkg::INSTR_OFFS, {5'h0, tgt, opnd, 4'h0, op}, mcis_pkg::RESP_OKAY, "instr");
		repeat (3) @(posedge aclk);
		pc = (pc + 1) % 2048;
		case (op)
			4'h1: acc = ~m[a] & 255;
			4'h2: begin
				s = acc + ((acc % 16 > 9 || h) ? 6 : 0) + ((acc / 16 > 9 || c) ? 96 : 0);
				m[a] = s % 256;
				c = acc / 16 > 9 || c || s > 255;
			end
			4'h3: m[a] = (m[a] + 255) % 256;
			4'h4: acc = (m[a] + 255) % 256;
			4'h5: m[a] = (m[a] + 1) % 256;
			4'h6: acc = (m[a] + 1) % 256;
			4'h8: pc = tgt;
			4'h9: acc = m[a];
			4'ha: acc = opnd;
			4'hb: m[a] = acc;
			default: ;
		endcase
		if (op inside {4'h1, 4'h4, 4'h6}) z = acc == 0;
		if (op inside {4'h3, 4'h5}) z = m[a] == 0;
		rdck(mcis_pkg::ACC_OFFS, 32'hff, 32'(acc), "acc");
		rdck(ma(a), 32'hff, 32'(m[a]), "mem");
		rdck(mcis_pkg::STATUS_OFFS, 32'h7, 32'(h * 4 + c * 2 + z), "flags");
		rdck(mcis_pkg::PC_OFFS, 32'h7ff, 32'(pc), "pc");
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdck(mcis_pkg::STATUS_OFFS, 32'h7f, 32'h0, "st_rst");
		rdck(mcis_pkg::ACC_OFFS, 32'hffffffff, 32'h0, "acc_rst");
		rdck(mcis_pkg::PC_OFFS, 32'hffffffff, 32'h0, "pc_rst");
		// Byte boundaries first, so wraparound and zero cases are hit
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			m[i] = (i == 0) ? 0 : (i == 1) ? 255 : (i == 2) ? 1 : int'(seed[7:0]);
			wrck(ma(i), 32'(m[i]), mcis_pkg::RESP_OKAY, "mem_wr");
		end
		foreach (ops[k]) begin
			for (int i = 0; i < 4; i++) run(ops[k], 8'(i), 11'h0);
		end
		for (int k = 0; k < 6; k++) begin
			acc = bcd_a[k];
			h = bcd_f[k] / 4;
			c = (bcd_f[k] / 2) % 2;
			z = 1;
			wrck(mcis_pkg::ACC_OFFS, 32'(acc), mcis_pkg::RESP_OKAY, "acc_wr");
			wrck(mcis_pkg::STATUS_OFFS, 32'(bcd_f[k] + 1), mcis_pkg::RESP_OKAY, "st_wr");
			run(4'h2, 8'(k), 11'h0);
		end
		seed = xs(seed);
		run(4'ha, seed[7:0] & 8'hc7, 11'h0);
		run(4'hb, 8'h6, 11'h0);
		run(4'h8, 8'h0, 11'h5a3);
		wrck(12'h020, 32'h5, mcis_pkg::RESP_SLVERR, "bad_wr");
		rdck(12'h200, 32'hffffffff, 32'h0, "bad_rd");
		`CK("bad_rresp", mcis_pkg::RESP_SLVERR, r)
		run(4'h7, 8'h0, 11'h0);
		`CK("clk_off", 1'b1, clk_off)
		rdck(mcis_pkg::STATUS_OFFS, 32'h58, 32'h48, "pd_flags");
		rdck(mcis_pkg::WDOG_OFFS, 32'hff00ff, 32'h0, "wdog");
		wrck(ma(0), 32'h5a, mcis_pkg::RESP_SLVERR, "halt_wr");
		rdck(ma(0), 32'hff, 32'(m[0]), "mem_kept");
		rdck(mcis_pkg::ACC_OFFS, 32'hff, 32'(acc), "acc_kept");
		wrck(mcis_pkg::CTRL_OFFS, 32'h1, mcis_pkg::RESP_OKAY, "wake");
		`CK("clk_on", 1'b0, clk_off)
		run(4'h5, 8'h1, 11'h0);
		wrap_up();
	end
endmodule
bind mcis_core_top mcis_core_monitor mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .sys_clk_off(sys_clk_off));
`default_nettype wire

// ===== dv/mcis_host_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module mcis_host_bfm (
	// Clock
	input wire logic aclk,
	// Register bus
	output var mcis_pkg::mcis_axi_req_t req,
	input wire mcis_pkg::mcis_axi_rsp_t rsp
);
	// Every other transfer holds its answer off a cycle so the slave must stall
	bit slow = 1'b0;
	initial req = '0;
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ack;
		logic done;
		ack = slow;
		slow = !slow;
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= ack;
		do begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			done = ack && (rsp.bvalid === 1'b1);
			if (!ack && (rsp.bvalid === 1'b1)) begin
				ack = 1'b1;
				req.bready <= 1'b1;
			end
		end while (!done);
		r = rsp.bresp;
		req.bready <= 1'b0;
		// Extra edge so a following call never re-drives in the same step
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ack;
		logic done;
		ack = slow;
		slow = !slow;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= ack;
		do begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			done = ack && (rsp.rvalid === 1'b1);
			if (!ack && (rsp.rvalid === 1'b1)) begin
				ack = 1'b1;
				req.rready <= 1'b1;
			end
		end while (!done);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask
endmodule
`default_nettype wire
